// ===== hdl/rtcs_ctrl.sv
// Status, control and interrupt logic of the real-time clock.
`timescale 1ns/1ps
`include "rtcs_params.svh"

module rtcs_ctrl
	import rtcs_pkg::*;
#(
	parameter int ALARM_DELAY_CYC = `RTCS_ALARM_DELAY_CYC,
	parameter int ADJ_PERIOD_SEC = `RTCS_ADJ_PERIOD_SEC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic osc_clk,
	input wire rtcs_regreq_s reg_req,
	output logic [7:0] reg_rdata,
	input wire rtcs_sense_s sense,
	input wire rtcs_wrap_s wrap,
	input wire logic daily_alarm_match,
	input wire logic weekly_alarm_match,
	output logic sec_increment,
	output logic hour_mode_24,
	output logic irq_out_first_n,
	output logic irq_out_second_n,
	output logic osc_clock_out
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	rtcs_sys_s s;
	rtcs_sys_s next_s;
	rtcs_osc_s o;
	rtcs_osc_s next_o;

	// Delays an alarm match by the flag-setting latency; disabled alarms hold nothing.
	function automatic rtcs_alarm_s alarm_step(input rtcs_alarm_s a, input logic en,
			input logic match);
		rtcs_alarm_s r;
		r = a;
		r.fire = 1'b0;
		if (!en) begin
			r.pend = 1'b0;
			r.cnt = '0;
		end else if (match) begin
			r.pend = 1'b1;
			r.cnt = 11'(ALARM_DELAY_CYC - 1);
		end else if (a.pend) begin
			if (a.cnt == '0) begin
				r.pend = 1'b0;
				r.fire = 1'b1;
			end else begin
				r.cnt = a.cnt - 11'h001;
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------------------
	// Oscillator domain: sub-second divider, pulse wave, seconds tick
	// ------------------------------------------------------------------------
	always_comb begin
		rtcs_pmode_e om;
		logic [6:0] delta;
		logic [14:0] tick_at;
		logic tick;
		om = rtcs_mode(o.cfg.sel);
		delta = '0;
		tick_at = '0;
		tick = 1'b0;
		next_o = o;
		next_o.rs = {o.rs[0], rst};
		if (o.rs[1]) begin
			next_o = '0;
			next_o.rs = {o.rs[0], rst};
		end else begin
			next_o.sw = {o.sw[1:0], s.sec_wr_tgl};
			next_o.rq = {o.rq[0], s.cfg_req};
			// Capture happens only while the request is open, so the word is stable.
			if (o.rq[1] != o.ack) begin
				next_o.cfg = s.cfg_xfer;
				next_o.ack = o.rq[1];
			end
			// R6 adjust step size
			delta = ({1'b0, o.cfg.adj_mag} << 1) > 7'(`RTCS_ADJ_MAX_CYC) ?
				7'(`RTCS_ADJ_MAX_CYC) : 7'({o.cfg.adj_mag, 1'b0});
			// R2 delayed increment
			tick_at = (om == RTCS_PM_PULSE) ? 15'(`RTCS_SEC_DELAY_CYC) : '0;
			if (o.sw[2] ^ o.sw[1]) begin
				// R3 clear divider
				next_o.div = '0;
				next_o.stall = '0;
			end else if (o.stall != '0) begin
				next_o.stall = o.stall - 7'h01;
			end else begin
				next_o.div = (o.div == `RTCS_DIV_TOP) ? '0 : o.div + 15'h0001;
				// R6 once per period
				if (o.div == `RTCS_ADJ_POINT && o.sec_cnt == '0 && delta != '0) begin
					if (o.cfg.adj_sign) begin
						next_o.div = o.div + 15'h0001 + 15'(delta);
					end else begin
						next_o.stall = delta;
					end
				end
				tick = (o.div == tick_at);
			end
			// R5 tick edge shared
			if (tick) begin
				next_o.tick_tgl = ~o.tick_tgl;
				next_o.sec_cnt = (o.sec_cnt >= 6'(ADJ_PERIOD_SEC - 1)) ? '0 :
					o.sec_cnt + 6'h01;
			end
			// R1 square wave
			next_o.pulse_low = (o.cfg.sel == `RTCS_SEL_2HZ) ? ~o.div[13] : ~o.div[14];
		end
	end

	always_ff @(posedge osc_clk) begin
		o <= next_o;
	end

	// ------------------------------------------------------------------------
	// System domain: registers, flags and pins
	// ------------------------------------------------------------------------
	always_comb begin
		rtcs_pmode_e m;
		logic tick_ev;
		logic wr_c2;
		logic lvl_hit;
		logic per_low;
		logic [7:0] c2;
		lvl_hit = 1'b0;
		per_low = 1'b0;
		c2 = 8'h00;
		m = rtcs_mode(s.ctrl1[`RTCS_C1_SEL_HI:`RTCS_C1_SEL_LO]);
		next_s = s;
		next_s.s_hi = {s.s_hi[0], sense.below_hi};
		next_s.s_lo = {s.s_lo[0], sense.below_lo};
		next_s.s_halt = {s.s_halt[0], sense.halt};
		next_s.s_ck = {s.s_ck[0], osc_clk};
		next_s.s_tick = {s.s_tick[1:0], o.tick_tgl};
		next_s.s_pls = {s.s_pls[0], o.pulse_low};
		next_s.s_ack = {s.s_ack[0], o.ack};
		tick_ev = s.s_tick[2] ^ s.s_tick[1];
		next_s.sec_inc = tick_ev;
		wr_c2 = reg_req.wr && reg_req.addr == `RTCS_ADDR_CTRL2;

		// R3 seconds write
		if (reg_req.wr && reg_req.addr == `RTCS_ADDR_SEC) begin
			next_s.sec_wr_tgl = ~s.sec_wr_tgl;
		end
		if (reg_req.wr && reg_req.addr == `RTCS_ADDR_ADJ) begin
			next_s.adj = reg_req.wdata;
		end
		if (reg_req.wr && reg_req.addr == `RTCS_ADDR_CTRL1) begin
			next_s.ctrl1 = reg_req.wdata;
		end
		if (wr_c2) begin
			next_s.vsel = reg_req.wdata[`RTCS_C2_VSEL];
			next_s.clka = reg_req.wdata[`RTCS_C2_CLKA];
			// R10 software rewrite
			next_s.halt_n = reg_req.wdata[`RTCS_C2_HALT];
			// R9 clear by zero
			if (!reg_req.wdata[`RTCS_C2_VLOW]) begin
				next_s.vlow = 1'b0;
			end
			// R13 clear by zero
			if (!reg_req.wdata[`RTCS_C2_PU]) begin
				next_s.pu = 1'b0;
			end
			// R16 level release
			if (!reg_req.wdata[`RTCS_C2_PIF] && m == RTCS_PM_LEVEL) begin
				next_s.lvl_irq = 1'b0;
			end
			// R18 alarm clear
			if (!reg_req.wdata[`RTCS_C2_WAF]) begin
				next_s.waf = 1'b0;
			end
			if (!reg_req.wdata[`RTCS_C2_DAF]) begin
				next_s.daf = 1'b0;
			end
		end

		// R7 R8 monitor trip
		if (!s.vlow && (s.vsel ? s.s_lo[1] : s.s_hi[1])) begin
			next_s.vlow = 1'b1;
		end
		// R10 halt detect
		if (s.s_halt[1]) begin
			next_s.halt_n = 1'b0;
		end

		// R4 cycle select
		case (s.ctrl1[`RTCS_C1_SEL_HI:`RTCS_C1_SEL_LO])
			`RTCS_SEL_SEC: lvl_hit = 1'b1;
			`RTCS_SEL_MIN: lvl_hit = wrap.sec_at_59;
			`RTCS_SEL_HOUR: lvl_hit = wrap.sec_at_59 && wrap.min_at_59;
			`RTCS_SEL_MONTH: lvl_hit = wrap.sec_at_59 && wrap.min_at_59 && wrap.month_ends;
			default: lvl_hit = 1'b0;
		endcase
		if (m != RTCS_PM_LEVEL) begin
			next_s.lvl_irq = 1'b0;
		end else if (tick_ev && lvl_hit) begin
			// R5 assert with increment
			next_s.lvl_irq = 1'b1;
		end

		// R17 R23 alarm delay
		next_s.al_d = alarm_step(s.al_d, s.ctrl1[`RTCS_C1_DAL], daily_alarm_match);
		next_s.al_w = alarm_step(s.al_w, s.ctrl1[`RTCS_C1_WAL], weekly_alarm_match);
		if (s.al_d.fire) begin
			next_s.daf = 1'b1;
		end
		if (s.al_w.fire) begin
			next_s.waf = 1'b1;
		end
		// R19 disabled reads zero
		if (!s.ctrl1[`RTCS_C1_DAL]) begin
			next_s.daf = 1'b0;
		end
		if (!s.ctrl1[`RTCS_C1_WAL]) begin
			next_s.waf = 1'b0;
		end

		// R12 power-up clears
		if (s.pu) begin
			next_s.ctrl1 = `RTCS_CTRL1_RST;
			next_s.adj = `RTCS_ADJ_RST;
			next_s.vsel = 1'b0;
			next_s.vlow = 1'b0;
			next_s.clka = 1'b0;
			next_s.lvl_irq = 1'b0;
			next_s.waf = 1'b0;
			next_s.daf = 1'b0;
		end

		// Configuration goes over only when the previous transfer is acknowledged.
		if (s.s_ack[1] == s.cfg_req &&
			(s.cfg_xfer.sel != s.ctrl1[`RTCS_C1_SEL_HI:`RTCS_C1_SEL_LO] ||
			s.cfg_xfer.adj_sign != s.adj[`RTCS_ADJ_SIGN] ||
			s.cfg_xfer.adj_mag != s.adj[`RTCS_ADJ_MAG_HI:0])) begin
			next_s.cfg_xfer.sel = s.ctrl1[`RTCS_C1_SEL_HI:`RTCS_C1_SEL_LO];
			next_s.cfg_xfer.adj_sign = s.adj[`RTCS_ADJ_SIGN];
			next_s.cfg_xfer.adj_mag = s.adj[`RTCS_ADJ_MAG_HI:0];
			next_s.cfg_req = ~s.cfg_req;
		end

		// R22 output per select
		case (m)
			RTCS_PM_LOW: per_low = 1'b1;
			RTCS_PM_PULSE: per_low = s.s_pls[1];
			RTCS_PM_LEVEL: per_low = s.lvl_irq;
			default: per_low = 1'b0;
		endcase
		// R20 R24 pin drive
		next_s.irq_a_n = ~(per_low | s.daf);
		next_s.irq_b_n = ~s.waf;
		// R14 clock gating
		next_s.clk_out = s.s_ck[1] & ~(s.clka & s.ctrl1[`RTCS_C1_CLKB]);

		// R15 R21 status readback
		c2 = {s.vsel, s.vlow, s.halt_n, s.pu, s.clka, ~s.irq_a_n & ~s.daf, s.waf, s.daf};
		c2[`RTCS_C2_PIF] = per_low;
		if (reg_req.rd) begin
			case (reg_req.addr)
				`RTCS_ADDR_ADJ: next_s.rdata = s.adj;
				`RTCS_ADDR_CTRL1: next_s.rdata = s.ctrl1;
				`RTCS_ADDR_CTRL2: next_s.rdata = c2;
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// Power-on from zero volts is the reset; the halt bit's undefined value is taken as 0.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
			// R11 set at power-on
			s.pu <= 1'b1;
			s.irq_a_n <= 1'b1;
			s.irq_b_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign sec_increment = s.sec_inc;
	assign hour_mode_24 = s.ctrl1[`RTCS_C1_H24];
	assign irq_out_first_n = s.irq_a_n;
	assign irq_out_second_n = s.irq_b_n;
	assign osc_clock_out = s.clk_out;

endmodule

// ===== hdl/rtcs_params.svh
// Constants for the RTC status, control and interrupt block.
//
// What this block does
// R1 - Pulse mode drives periodic output as 2 Hz or 1 Hz square wave on seconds.
// R2 - In pulse mode the seconds increment comes about 92 us after the falling edge.
// R3 - Seconds write clears sub-second divider; in pulse mode the periodic pin goes low.
// R4 - Level mode asserts periodic interrupt once per second, minute, hour or month.
// R5 - Level mode flag sets with the seconds increment; the first pin falls one system clock later.
// R6 - Adjustment changes one interval every 20 or 60 s by at most 3.784 ms.
// R7 - Threshold select 0 picks the 2.1 V trip, 1 picks the 1.3 V trip.
// R8 - Supply-low flag sets below threshold, then monitor stops and flag holds.
// R9 - Writing 0 clears supply-low flag and restarts monitor; writing 1 does nothing.
// R10 - Oscillation-halt bit is read/write, cleared on halt, stays 0 until rewritten.
// R11 - Power-up flag sets on power-on from zero volts and stays set.
// R12 - While power-up flag is set, adjustment and control bits clear; pins release.
// R13 - Power-up flag clears only by writing 0; writing 1 does nothing.
// R14 - Clock output runs when either clock-disable bit is 0, low when both are 1.
// R15 - Periodic flag reads 1 while periodic pin is low, 0 while high.
// R16 - In level mode writing 0 to periodic flag releases pin until next cycle.
// R17 - Enabled alarm flag sets about 61 us after the time matches its alarm.
// R18 - Writing 0 to an alarm flag clears it and releases its pin until next match.
// R19 - An alarm flag reads 0 while its enable bit is 0.
// R20 - Weekly flag drives second pin; daily flag drives first pin shared with periodic.
// R21 - After power-up the second control register reads with power-up flag 1, rest 0.
// R22 - Select 000 high, 001 low, 010 2 Hz, 011 1 Hz, 100-111 level cycles.
// R23 - Each alarm enable turns its alarm interrupt circuit on or off.
// R24 - Both interrupt pins are active low and released high when nothing asserts.
`ifndef RTCS_PARAMS_SVH
`define RTCS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RTCS_ADDR_SEC 4'h0
`define RTCS_ADDR_ADJ 4'h7
`define RTCS_ADDR_CTRL1 4'hE
`define RTCS_ADDR_CTRL2 4'hF

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RTCS_C1_WAL 7
`define RTCS_C1_DAL 6
`define RTCS_C1_H24 5
`define RTCS_C1_CLKB 4
`define RTCS_C1_SEL_HI 2
`define RTCS_C1_SEL_LO 0
`define RTCS_C2_VSEL 7
`define RTCS_C2_VLOW 6
`define RTCS_C2_HALT 5
`define RTCS_C2_PU 4
`define RTCS_C2_CLKA 3
`define RTCS_C2_PIF 2
`define RTCS_C2_WAF 1
`define RTCS_C2_DAF 0
`define RTCS_ADJ_SIGN 6
`define RTCS_ADJ_MAG_HI 5

// ----------------------------------------------------------------------------
// Periodic select codes and reset values
// ----------------------------------------------------------------------------
`define RTCS_SEL_OFF 3'h0
`define RTCS_SEL_LOW 3'h1
`define RTCS_SEL_2HZ 3'h2
`define RTCS_SEL_1HZ 3'h3
`define RTCS_SEL_SEC 3'h4
`define RTCS_SEL_MIN 3'h5
`define RTCS_SEL_HOUR 3'h6
`define RTCS_SEL_MONTH 3'h7
`define RTCS_CTRL1_RST 8'h00
`define RTCS_ADJ_RST 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTCS_SYS_CLK_NS 50
`define RTCS_OSC_HZ 32768
`define RTCS_ALARM_DELAY_NS 61000
`define RTCS_ALARM_DELAY_CYC ((`RTCS_ALARM_DELAY_NS + `RTCS_SYS_CLK_NS - 1) / `RTCS_SYS_CLK_NS)
`define RTCS_SEC_DELAY_US 92
`define RTCS_SEC_DELAY_CYC ((`RTCS_SEC_DELAY_US * `RTCS_OSC_HZ) / 1000000)
`define RTCS_ADJ_MAX_US 3784
`define RTCS_ADJ_MAX_CYC ((`RTCS_ADJ_MAX_US * `RTCS_OSC_HZ) / 1000000)
`define RTCS_ADJ_PERIOD_SEC 20
`define RTCS_DIV_TOP 15'h7FFF
`define RTCS_ADJ_POINT 15'h1000

`endif

// ===== hdl/rtcs_pkg.sv
// Types shared by the RTC status, control and interrupt block.
package rtcs_pkg;

	typedef enum {RTCS_PM_HIGH, RTCS_PM_LOW, RTCS_PM_PULSE, RTCS_PM_LEVEL} rtcs_pmode_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} rtcs_regreq_s;

	typedef struct packed {
		logic below_hi;
		logic below_lo;
		logic halt;
	} rtcs_sense_s;

	typedef struct packed {
		logic sec_at_59;
		logic min_at_59;
		logic month_ends;
	} rtcs_wrap_s;

	typedef struct packed {
		logic [2:0] sel;
		logic adj_sign;
		logic [5:0] adj_mag;
	} rtcs_cfg_s;

	typedef struct packed {
		logic fire;
		logic pend;
		logic [10:0] cnt;
	} rtcs_alarm_s;

	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] adj;
		logic vsel;
		logic vlow;
		logic halt_n;
		logic pu;
		logic clka;
		logic lvl_irq;
		logic waf;
		logic daf;
		logic [1:0] s_hi;
		logic [1:0] s_lo;
		logic [1:0] s_halt;
		logic [1:0] s_ck;
		logic [2:0] s_tick;
		logic [1:0] s_pls;
		logic [1:0] s_ack;
		logic cfg_req;
		rtcs_cfg_s cfg_xfer;
		logic sec_wr_tgl;
		rtcs_alarm_s al_d;
		rtcs_alarm_s al_w;
		logic irq_a_n;
		logic irq_b_n;
		logic clk_out;
		logic sec_inc;
		logic [7:0] rdata;
	} rtcs_sys_s;

	typedef struct packed {
		logic [1:0] rs;
		logic [2:0] sw;
		logic [1:0] rq;
		logic ack;
		rtcs_cfg_s cfg;
		logic [14:0] div;
		logic [6:0] stall;
		logic [5:0] sec_cnt;
		logic tick_tgl;
		logic pulse_low;
	} rtcs_osc_s;

	function automatic rtcs_pmode_e rtcs_mode(input logic [2:0] sel);
		rtcs_pmode_e m;
		m = RTCS_PM_LEVEL;
		case (sel)
			3'h0: m = RTCS_PM_HIGH;
			3'h1: m = RTCS_PM_LOW;
			3'h2, 3'h3: m = RTCS_PM_PULSE;
			default: m = RTCS_PM_LEVEL;
		endcase
		return m;
	endfunction

endpackage

// ===== tb/rtcs_ctrl_props.sv
// Port checker for the RTC status, control and interrupt block.
`timescale 1ns/1ps
module rtcs_ctrl_props
	import rtcs_pkg::*;
#(
	parameter int ALARM_DELAY_CYC = 5
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire rtcs_regreq_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire rtcs_sense_s sense,
	input wire logic weekly_alarm_match,
	input wire logic sec_increment,
	input wire logic hour_mode_24,
	input wire logic irq_out_first_n,
	input wire logic irq_out_second_n,
	input wire logic osc_clock_out
);
	localparam int AL_HI = ALARM_DELAY_CYC + 4;
	typedef struct packed {
		logic [15:0] since_w;
		logic [2:0] gap;
		logic pu;
	} rtcs_chk_s;
	rtcs_chk_s q;
	rtcs_chk_s next_q;
	logic wr_f;
	assign wr_f = reg_req.wr && reg_req.addr == 4'hF;
	// The power-up flag is mirrored from writes alone, so it is trusted only from reset on.
	always_comb begin
		next_q = q;
		if (weekly_alarm_match) begin
			next_q.since_w = 16'h0000;
		end else if (q.since_w != 16'hFFFF) begin
			next_q.since_w = q.since_w + 16'h0001;
		end
		if (reg_req.wr) begin
			next_q.gap = 3'h0;
		end else if (q.gap != 3'h7) begin
			next_q.gap = q.gap + 3'h1;
		end
		if (wr_f && !reg_req.wdata[4]) begin
			next_q.pu = 1'b0;
		end
		if (rst) begin
			next_q = '{since_w: 16'hFFFF, gap: 3'h0, pu: 1'b1};
		end
	end
	always_ff @(posedge sys_clk) begin
		q <= next_q;
	end
	default clocking cb @(posedge sys_clk); endclocking
	sequence halt_seen;
		sense.halt [*6];
	endsequence
	sequence read_ctrl2;
		reg_req.rd && reg_req.addr == 4'hF;
	endsequence
	a_reset_pins_idle: assert property (rst |=> irq_out_first_n && irq_out_second_n
		&& !sec_increment && !osc_clock_out) else $error("Pins not idle after reset.");
	a_second_pin_cause: assert property (disable iff (rst) $fell(irq_out_second_n)
		|-> q.since_w inside {[ALARM_DELAY_CYC:AL_HI]}) else $error("Second pin fell off time.");
	a_second_pin_clear: assert property (disable iff (rst) wr_f && !reg_req.wdata[1]
		&& q.since_w > AL_HI + 4 |-> ##[1:3] irq_out_second_n) else $error("Second pin held.");
	a_sec_spacing: assert property (disable iff (rst) sec_increment
		|=> !sec_increment [*8]) else $error("Seconds pulses too close.");
	a_rdata_holds: assert property (disable iff (rst) !reg_req.rd
		|=> $stable(reg_rdata)) else $error("Read data changed without a read.");
	a_unmapped_zero: assert property (disable iff (rst) reg_req.rd
		&& !(reg_req.addr inside {4'h0, 4'h7, 4'hE, 4'hF}) |=> reg_rdata == 8'h00)
		else $error("Unmapped read not zero.");
	a_pu_ctrl1_clear: assert property (disable iff (rst) q.pu && q.gap > 3'h1
		&& !reg_req.wr && reg_req.rd && reg_req.addr == 4'hE |=> reg_rdata == 8'h00)
		else $error("Control one not cleared under power-up.");
	a_pu_mode_low: assert property (disable iff (rst) q.pu && q.gap > 3'h2
		|-> !hour_mode_24) else $error("Hour mode set under power-up.");
	a_halt_read: assert property (disable iff (rst) halt_seen ##0 read_ctrl2
		|=> !reg_rdata[5]) else $error("Halt bit not cleared.");
endmodule

bind rtcs_ctrl rtcs_ctrl_props #(.ALARM_DELAY_CYC(ALARM_DELAY_CYC)) u_props (
	.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .sense(sense),
	.weekly_alarm_match(weekly_alarm_match), .sec_increment(sec_increment),
	.hour_mode_24(hour_mode_24), .irq_out_first_n(irq_out_first_n),
	.irq_out_second_n(irq_out_second_n), .osc_clock_out(osc_clock_out)
);

// ===== tb/rtcs_host.sv
// Host processor model driving the block's register port.
`timescale 1ns/1ps
module rtcs_host
	import rtcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata,
	output rtcs_regreq_s reg_req
);
	initial begin
		reg_req = '0;
	end
	// flags cleared by zero.
	// Idle address and data are inverted so a stale value never looks valid.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_req.wr <= 1'b1;
		reg_req.addr <= a;
		reg_req.wdata <= d;
		@(posedge sys_clk);
		reg_req.wr <= 1'b0;
		reg_req.addr <= ~a;
		reg_req.wdata <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_req.rd <= 1'b1;
		reg_req.addr <= a;
		@(posedge sys_clk);
		reg_req.rd <= 1'b0;
		reg_req.addr <= ~a;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask
endmodule

// ===== tb/rtcs_ctrl_tb.sv
// Self-checking testbench for the RTC status, control and interrupt block.
`timescale 1ns/1ps
module rtcs_ctrl_tb
	import rtcs_pkg::*;
;
	logic sys_clk = 1'b0;
	logic osc_clk = 1'b0;
	logic rst = 1'b1;
	rtcs_sense_s sense = '0;
	rtcs_wrap_s wrap = '0;
	logic dm = 1'b0;
	logic wm = 1'b0;
	rtcs_regreq_s reg_req;
	logic [7:0] reg_rdata;
	logic [7:0] v;
	logic sec_increment, hour_mode_24, irq_out_first_n, irq_out_second_n, osc_clock_out;
	int n_errors = 0;
	int checks_done = 0;
	int t;
	logic p;
	always #25 sys_clk = ~sys_clk;
	always #16 osc_clk = ~osc_clk;
	// Only the seconds wrap is driven, so the hour and month cycles are left untested.
	rtcs_ctrl #(.ALARM_DELAY_CYC(5), .ADJ_PERIOD_SEC(20)) DUT (.sys_clk(sys_clk), .rst(rst),
		.osc_clk(osc_clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .sense(sense), .wrap(wrap),
		.daily_alarm_match(dm), .weekly_alarm_match(wm), .sec_increment(sec_increment),
		.hour_mode_24(hour_mode_24), .irq_out_first_n(irq_out_first_n),
		.irq_out_second_n(irq_out_second_n), .osc_clock_out(osc_clock_out));
	rtcs_host host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		host.rd(a, v);
		chk($sformatf("register %h", a), e, v);
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
	endtask
	task automatic wait_pin(input bit b, input logic lvl, input int lim);
		int n;
		n = 0;
		while ((b ? irq_out_second_n : irq_out_first_n) !== lvl && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk(b ? "second pin" : "first pin", {7'h00, lvl},
			{7'h00, b ? irq_out_second_n : irq_out_first_n});
	endtask
	task automatic wait_sec(input int lim);
		int n;
		n = 0;
		while (sec_increment !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk("seconds increment", 8'h01, {7'h00, sec_increment});
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rc(4'hF, 8'h10);
		rc(4'hE, 8'h00);
		rc(4'h3, 8'h00);
		host.wr(4'hE, 8'hFF);
		tick(3);
		rc(4'hE, 8'h00);
		host.wr(4'hF, 8'h7F);
		rc(4'hF, 8'h30);
		host.wr(4'hF, 8'h20);
		host.wr(4'hF, 8'h7F);
		rc(4'hF, 8'h28);
		for (int i = 0; i < 3; i++) begin
			host.wr(4'hF, {4'h2, i != 1, 3'h0});
			host.wr(4'hE, {3'h1, i != 2, 4'h0});
			t = 0;
			tick(3);
			@(negedge sys_clk);
			p = osc_clock_out;
			repeat (40) begin
				@(negedge sys_clk);
				if (osc_clock_out !== p) t++;
				p = osc_clock_out;
			end
			chk("clock output running", {7'h00, i != 0}, {7'h00, t > 0});
		end
		host.wr(4'hF, 8'h20);
		sense.below_hi <= 1'b1;
		tick(8);
		sense.below_hi <= 1'b0;
		tick(8);
		rc(4'hF, 8'h60);
		host.wr(4'hF, 8'h20);
		rc(4'hF, 8'h20);
		host.wr(4'hF, 8'hA0);
		sense.below_hi <= 1'b1;
		tick(8);
		rc(4'hF, 8'hA0);
		sense.below_lo <= 1'b1;
		tick(8);
		rc(4'hF, 8'hE0);
		sense <= '0;
		tick(6);
		host.wr(4'hF, 8'h20);
		sense.halt <= 1'b1;
		tick(8);
		rc(4'hF, 8'h00);
		sense.halt <= 1'b0;
		tick(8);
		rc(4'hF, 8'h00);
		host.wr(4'hF, 8'h20);
		rc(4'hF, 8'h20);
		host.wr(4'hE, 8'hC0);
		dm <= 1'b1;
		tick(1);
		dm <= 1'b0;
		wait_pin(0, 1'b0, 20);
		rc(4'hF, 8'h21);
		host.wr(4'hF, 8'h20);
		wait_pin(0, 1'b1, 4);
		wm <= 1'b1;
		tick(1);
		wm <= 1'b0;
		wait_pin(1, 1'b0, 20);
		rc(4'hF, 8'h22);
		tick(4);
		host.wr(4'hF, 8'h20);
		wait_pin(1, 1'b1, 4);
		wm <= 1'b1;
		tick(1);
		wm <= 1'b0;
		wait_pin(1, 1'b0, 20);
		host.wr(4'hE, 8'h40);
		rc(4'hF, 8'h20);
		wait_pin(1, 1'b1, 4);
		wm <= 1'b1;
		tick(1);
		wm <= 1'b0;
		tick(12);
		chk("second pin", 8'h01, {7'h00, irq_out_second_n});
		host.wr(4'hE, 8'h03);
		tick(3);
		wait_pin(0, 1'b1, 11000);
		wait_pin(0, 1'b0, 11000);
		wait_sec(12);
		host.wr(4'hE, 8'h02);
		wait_pin(0, 1'b1, 6000);
		host.wr(4'h0, 8'h00);
		wait_pin(0, 1'b0, 15);
		wait_pin(0, 1'b1, 6000);
		host.wr(4'hE, 8'h01);
		wait_pin(0, 1'b0, 20);
		host.wr(4'hE, 8'h00);
		wait_pin(0, 1'b1, 20);
		host.wr(4'hE, 8'h04);
		wait_sec(22000);
		chk("first pin", 8'h01, {7'h00, irq_out_first_n});
		tick(1);
		chk("first pin", 8'h00, {7'h00, irq_out_first_n});
		rc(4'hF, 8'h24);
		host.wr(4'hF, 8'h20);
		wait_pin(0, 1'b1, 4);
		rc(4'hF, 8'h20);
		wait_sec(22000);
		wait_pin(0, 1'b0, 2);
		host.wr(4'hE, 8'h05);
		host.wr(4'hF, 8'h20);
		tick(10);
		host.wr(4'h0, 8'h00);
		wait_sec(30);
		tick(2);
		chk("first pin", 8'h01, {7'h00, irq_out_first_n});
		wrap.sec_at_59 <= 1'b1;
		host.wr(4'h0, 8'h00);
		wait_sec(30);
		wait_pin(0, 1'b0, 2);
		tally_and_finish();
	end
endmodule
